// >>> gpt_pkg.sv
/*
  Package for the general-purpose timer: register indices, field layout of
  the setup register, source and rate codes, reset values and bus constants.
  Assumes a single 32-bit AHB-Lite slave port in front of the timer.
*/
package gpt_pkg;

  // ==========================================================================
  // Register indices and byte addresses (byte address is four times the index)
  // ==========================================================================
  localparam logic [19:0] IDX_SETUP = 20'h4C000;
  localparam logic [19:0] IDX_PRESET = 20'h4C002;
  localparam logic [19:0] IDX_START_STOP = 20'h4C006;
  localparam logic [19:0] IDX_RUN_STATE = 20'h4C008;
  localparam logic [19:0] IDX_READBACK = 20'h4C00A;
  localparam logic [19:0] IDX_DSP_REQ = 20'h4C00C;
  localparam logic [19:0] IDX_DSP_ACH = 20'h4C00E;
  localparam logic [31:0] ADDR_SETUP = {10'h000, IDX_SETUP, 2'h0};
  localparam logic [31:0] ADDR_PRESET = {10'h000, IDX_PRESET, 2'h0};
  localparam logic [31:0] ADDR_START_STOP = {10'h000, IDX_START_STOP, 2'h0};
  localparam logic [31:0] ADDR_RUN_STATE = {10'h000, IDX_RUN_STATE, 2'h0};
  localparam logic [31:0] ADDR_READBACK = {10'h000, IDX_READBACK, 2'h0};
  localparam logic [31:0] ADDR_DSP_REQ = {10'h000, IDX_DSP_REQ, 2'h0};
  localparam logic [31:0] ADDR_DSP_ACH = {10'h000, IDX_DSP_ACH, 2'h0};

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int START_BIT = 0;
  localparam int STOP_BIT = 4;
  localparam int RUN_BIT = 0;

  // Setup register layout, bit 31 down to bit 0.
  typedef struct packed {
    logic [9:0] rsvd_hi;                   // 31:22
    logic auto_restart_select;             // 21
    logic count_direction;                 // 20
    logic rsvd_19;                         // 19
    logic [2:0] rate_prescaler;            // 18:16
    logic rsvd_15;                         // 15
    logic [2:0] reference_divider;         // 14:12
    logic rsvd_11;                         // 11
    logic [2:0] derived_reference_select;  // 10:8
    logic [3:0] rsvd_7_4;                  // 7:4
    logic [3:0] reference_source_select;   // 3:0
  } gpt_setup_t;

  localparam logic [31:0] SETUP_WMASK = 32'h0037_770F;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [31:0] PRESET_RESET = 32'h0000_0000;
  localparam logic [15:0] DSP_REQ_RESET = 16'h0000;

  // ==========================================================================
  // Source codes and rate codes
  // ==========================================================================
  localparam logic [3:0] SRC_DSP = 4'h0;
  localparam logic [3:0] SRC_32K = 4'h1;
  localparam logic [3:0] SRC_MCLK_A = 4'h4;
  localparam logic [3:0] SRC_MCLK_B = 4'h5;
  localparam logic [3:0] SRC_SYS = 4'h8;
  localparam logic [3:0] SRC_PIN_A = 4'hC;
  localparam logic [3:0] SRC_PIN_B = 4'hD;
  localparam logic [3:0] SRC_PIN_C = 4'hE;
  localparam logic [2:0] FREQ_SEL_MAX = 3'h3;  // 49.152 MHz; above is reserved.

  // Pin order inside the synchroniser vector.
  typedef enum logic [2:0] {
    PIN_32K = 3'b000,
    PIN_MCLK_A = 3'b001,
    PIN_MCLK_B = 3'b010,
    PIN_SYS = 3'b011,
    PIN_GP_A = 3'b100,
    PIN_GP_B = 3'b101,
    PIN_GP_C = 3'b110
  } gpt_pin_t;
  localparam int NUM_PINS = 7;

  // ==========================================================================
  // Timing: the core clock is the DSP core clock, in units of 1/64 MHz
  // ==========================================================================
  localparam int CORE_CLK_KHZ = 10000;
  localparam int FREQ_UNITS_PER_MHZ = 64;
  localparam logic [15:0] CORE_FREQ_UNITS = 16'(CORE_CLK_KHZ * FREQ_UNITS_PER_MHZ / 1000);

  // AHB-Lite constants.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : gpt_pkg

// >>> gpt_timer.sv
/*
  General-purpose 32-bit timer with an AHB-Lite register slave.
  Assumes core_clk is the DSP core clock, that the external reference pins
  are asynchronous to it, and that software stops the timer before changing
  its configuration.
*/
// Behaviour
// - Direction bit 0 counts down, 1 counts up; change only while stopped.
// - Prescaler divides by two to the power of the 3-bit field, bits 18:16.
// - Reference divider divides by 1 to 128 in powers of two, not for DSP.
// - With DSP clock disabled, divider output paces the event logger.
// - Derived reference select picks 6.144, 12.288, 24.576 or 49.152 MHz.
// - Four-bit source field selects DSP, 32k, master clocks, system, pins.
// - Preset is final count counting up, starting count counting down.
// - Start bit starts or restarts, stop bit halts.
// - Present count is a 32-bit read-only field, reset zero.
// - DSP reference request is 16 bits in 1/64 MHz steps.
// - DSP reference comes from integer division; achieved value readable.
// - Achieved value is 16 bits, 1/64 MHz steps, reset zero.
// - Running flag reads 1 while counting, 0 once stopped.
// - Continuous mode restarts at end of count; single mode stops.
// - End event fires when the next update after the end would be due.
`timescale 1ns/1ps

module gpt_timer #(
  parameter logic [1:0] SYS_RATE_CODE = 2'h3
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic dsp_clock_enable,
  input wire logic clk_32k_in,
  input wire logic master_clock_input_a,
  input wire logic master_clock_input_b,
  input wire logic main_system_clock,
  input wire logic general_pin_a,
  input wire logic general_pin_b,
  input wire logic general_pin_c,
  output logic running_flag,
  output logic end_event,
  output logic logger_tick
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // True when a tick completes a power-of-two division of 2**code.
  function automatic logic pow2_hit(input logic [7:0] cnt, input logic [2:0] code);
    logic [7:0] mask;
    mask = 8'((9'h001 << code) - 9'h001);
    return (cnt & mask) == mask;
  endfunction : pow2_hit

  // Integer quotient, zero-safe.
  function automatic logic [15:0] quot16(input logic [15:0] num, input logic [15:0] den);
    return (den == 16'h0000) ? 16'h0000 : num / den;
  endfunction : quot16

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [gpt_pkg::NUM_PINS-1:0] pins;
  logic [gpt_pkg::NUM_PINS-1:0] s1_ff, s2_ff, s3_ff;
  logic [gpt_pkg::NUM_PINS-1:0] pin_rise;

  assign pins = {general_pin_c, general_pin_b, general_pin_a, main_system_clock,
                 master_clock_input_b, master_clock_input_a, clk_32k_in};

  // Three stages; only the last two feed the edge detector so a metastable
  // first stage never reaches logic.
  always_comb begin
    pin_rise = s2_ff & ~s3_ff;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // ==========================================================================
  // Registers and bus slave state
  // ==========================================================================
  gpt_pkg::gpt_setup_t setup_ff, nxt_setup;
  logic [31:0] preset_ff, nxt_preset;
  logic [15:0] dsp_req_ff, nxt_dsp_req;
  logic [15:0] dsp_ach_ff, nxt_dsp_ach;
  logic [31:0] waddr_ff, nxt_waddr;
  logic wpend_ff, nxt_wpend;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [31:0] count_ff, nxt_count;
  logic running_ff, nxt_running;
  logic start_req, stop_req;

  logic addr_phase;
  logic [15:0] dsp_div;

  // The DSP reference divisor: a request above the core rate gets ratio one.
  always_comb begin
    if (dsp_req_ff == 16'h0000 || dsp_req_ff >= gpt_pkg::CORE_FREQ_UNITS) begin
      dsp_div = 16'h0001;
    end else begin
      dsp_div = quot16(gpt_pkg::CORE_FREQ_UNITS, dsp_req_ff);
    end
  end

  // Writes land in the data phase; reads are prepared in the address phase
  // so that hrdata comes straight from a flop with zero wait states.
  always_comb begin
    addr_phase = hsel && hready && htrans == gpt_pkg::HTRANS_NONSEQ;
    nxt_setup = setup_ff;
    nxt_preset = preset_ff;
    nxt_dsp_req = dsp_req_ff;
    nxt_dsp_ach = dsp_ach_ff;
    nxt_waddr = waddr_ff;
    nxt_wpend = addr_phase && hwrite;
    nxt_hrdata = 32'h0000_0000;
    start_req = 1'b0;
    stop_req = 1'b0;
    if (addr_phase) begin
      nxt_waddr = haddr;
    end
    if (wpend_ff) begin
      case (waddr_ff)
        gpt_pkg::ADDR_SETUP: nxt_setup = hwdata & gpt_pkg::SETUP_WMASK;
        gpt_pkg::ADDR_PRESET: nxt_preset = hwdata;
        gpt_pkg::ADDR_DSP_REQ: nxt_dsp_req = hwdata[15:0];
        gpt_pkg::ADDR_START_STOP: begin
          start_req = hwdata[gpt_pkg::START_BIT];
          stop_req = hwdata[gpt_pkg::STOP_BIT];
        end
        default: nxt_setup = setup_ff;
      endcase
    end
    if (setup_ff.reference_source_select == gpt_pkg::SRC_DSP) begin
      nxt_dsp_ach = quot16(gpt_pkg::CORE_FREQ_UNITS, dsp_div);
    end
    if (addr_phase && !hwrite) begin
      case (haddr)
        gpt_pkg::ADDR_SETUP: nxt_hrdata = setup_ff;
        gpt_pkg::ADDR_PRESET: nxt_hrdata = preset_ff;
        gpt_pkg::ADDR_RUN_STATE: nxt_hrdata = {31'h0000_0000, running_ff};
        gpt_pkg::ADDR_READBACK: nxt_hrdata = count_ff;
        gpt_pkg::ADDR_DSP_REQ: nxt_hrdata = {16'h0000, dsp_req_ff};
        gpt_pkg::ADDR_DSP_ACH: nxt_hrdata = {16'h0000, dsp_ach_ff};
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      setup_ff <= gpt_pkg::SETUP_RESET;
      preset_ff <= gpt_pkg::PRESET_RESET;
      dsp_req_ff <= gpt_pkg::DSP_REQ_RESET;
      dsp_ach_ff <= 16'h0000;
      waddr_ff <= 32'h0000_0000;
      wpend_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      setup_ff <= nxt_setup;
      preset_ff <= nxt_preset;
      dsp_req_ff <= nxt_dsp_req;
      dsp_ach_ff <= nxt_dsp_ach;
      waddr_ff <= nxt_waddr;
      wpend_ff <= nxt_wpend;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // ==========================================================================
  // Reference selection and divider chain
  // ==========================================================================
  logic [7:0] sys_cnt_ff, nxt_sys_cnt;
  logic [7:0] ref_cnt_ff, nxt_ref_cnt;
  logic [7:0] pre_cnt_ff, nxt_pre_cnt;
  logic [15:0] dsp_cnt_ff, nxt_dsp_cnt;
  logic ref_tick, div_tick, cnt_tick, sys_tick;
  logic [2:0] sys_shift;
  logic end_ff, nxt_end;
  logic log_ff, nxt_log;
  logic at_end;
  logic [31:0] init_val;

  // Each stage counts only the ticks of the stage before it; the counters except
  // sys_cnt_ff restart with the timer so the first count period is whole for every source but SRC_SYS.
  always_comb begin
    sys_shift = 3'(SYS_RATE_CODE) - setup_ff.derived_reference_select;
    nxt_sys_cnt = sys_cnt_ff;
    nxt_ref_cnt = ref_cnt_ff;
    nxt_pre_cnt = pre_cnt_ff;
    nxt_dsp_cnt = dsp_cnt_ff;
    sys_tick = 1'b0;
    ref_tick = 1'b0;
    div_tick = 1'b0;
    cnt_tick = 1'b0;
    // Derived reference from the system clock by the ratio of the two rates.
    if (pin_rise[gpt_pkg::PIN_SYS]) begin
      nxt_sys_cnt = sys_cnt_ff + 8'h01;
      if (setup_ff.derived_reference_select <= gpt_pkg::FREQ_SEL_MAX) begin
        sys_tick = setup_ff.derived_reference_select > 3'(SYS_RATE_CODE) ||
                   pow2_hit(sys_cnt_ff, sys_shift);
      end
    end
    case (setup_ff.reference_source_select)
      gpt_pkg::SRC_DSP: begin
        nxt_dsp_cnt = (dsp_cnt_ff + 16'h0001 >= dsp_div) ? 16'h0000 : dsp_cnt_ff + 16'h0001;
        ref_tick = dsp_cnt_ff + 16'h0001 >= dsp_div;
      end
      gpt_pkg::SRC_32K: ref_tick = pin_rise[gpt_pkg::PIN_32K];
      gpt_pkg::SRC_MCLK_A: ref_tick = pin_rise[gpt_pkg::PIN_MCLK_A];
      gpt_pkg::SRC_MCLK_B: ref_tick = pin_rise[gpt_pkg::PIN_MCLK_B];
      gpt_pkg::SRC_SYS: ref_tick = sys_tick;
      gpt_pkg::SRC_PIN_A: ref_tick = pin_rise[gpt_pkg::PIN_GP_A];
      gpt_pkg::SRC_PIN_B: ref_tick = pin_rise[gpt_pkg::PIN_GP_B];
      gpt_pkg::SRC_PIN_C: ref_tick = pin_rise[gpt_pkg::PIN_GP_C];
      default: ref_tick = 1'b0;
    endcase
    if (setup_ff.reference_source_select == gpt_pkg::SRC_DSP) begin
      div_tick = ref_tick;
    end else if (ref_tick) begin
      nxt_ref_cnt = ref_cnt_ff + 8'h01;
      div_tick = pow2_hit(ref_cnt_ff, setup_ff.reference_divider);
    end
    if (div_tick) begin
      nxt_pre_cnt = pre_cnt_ff + 8'h01;
      cnt_tick = pow2_hit(pre_cnt_ff, setup_ff.rate_prescaler);
    end
    if (start_req) begin
      nxt_ref_cnt = 8'h00;
      nxt_pre_cnt = 8'h00;
      nxt_dsp_cnt = 16'h0000;
    end
  end

  // ==========================================================================
  // Counter
  // ==========================================================================
  // The end is seen on the tick after the final value is reached, which is
  // when the next update would have been due; that tick raises the event.
  always_comb begin
    init_val = setup_ff.count_direction ? 32'h0000_0000 : preset_ff;
    at_end = setup_ff.count_direction ? (count_ff == preset_ff) : (count_ff == 32'h0000_0000);
    nxt_count = count_ff;
    nxt_running = running_ff;
    nxt_end = 1'b0;
    nxt_log = div_tick && !dsp_clock_enable;
    if (start_req) begin
      nxt_count = init_val;
      nxt_running = 1'b1;
    end else if (stop_req) begin
      nxt_running = 1'b0;
    end else if (running_ff && cnt_tick) begin
      if (at_end) begin
        nxt_end = 1'b1;
        if (setup_ff.auto_restart_select) begin
          nxt_count = init_val;
        end else begin
          nxt_running = 1'b0;
        end
      end else if (setup_ff.count_direction) begin
        nxt_count = count_ff + 32'h0000_0001;
      end else begin
        nxt_count = count_ff - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_cnt_ff <= 8'h00;
      ref_cnt_ff <= 8'h00;
      pre_cnt_ff <= 8'h00;
      dsp_cnt_ff <= 16'h0000;
      count_ff <= 32'h0000_0000;
      running_ff <= 1'b0;
      end_ff <= 1'b0;
      log_ff <= 1'b0;
    end else begin
      sys_cnt_ff <= nxt_sys_cnt;
      ref_cnt_ff <= nxt_ref_cnt;
      pre_cnt_ff <= nxt_pre_cnt;
      dsp_cnt_ff <= nxt_dsp_cnt;
      count_ff <= nxt_count;
      running_ff <= nxt_running;
      end_ff <= nxt_end;
      log_ff <= nxt_log;
    end
  end

  // AHB-Lite answer: always ready, always OKAY, from constant-reset flops.
  logic ready_ff;
  logic resp_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_ff <= 1'b1;
      resp_ff <= gpt_pkg::HRESP_OKAY;
    end else begin
      ready_ff <= 1'b1;
      resp_ff <= gpt_pkg::HRESP_OKAY;
    end
  end

  // Outputs are flop-driven.
  assign hrdata = hrdata_ff;
  assign hreadyout = ready_ff;
  assign hresp = resp_ff;
  assign running_flag = running_ff;
  assign end_event = end_ff;
  assign logger_tick = log_ff;

  // hsize is accepted as word-only; narrower sizes are treated as word.
  logic unused_size;
  assign unused_size = ^hsize;

endmodule : gpt_timer

// >>> gpt_timer_chk.sv
/*
  Port checker for the timer: bus answer, run flag, end and logger pulses.
  Assumes it is bound to gpt_timer and sees only that module's ports.
*/
`timescale 1ns/1ps
module gpt_timer_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic dsp_clock_enable,
  input wire logic running_flag,
  input wire logic end_event,
  input wire logic logger_tick
);
  // ==========
  // Address phase memory
  logic take, nxt_rd, nxt_ss, nxt_rs, rd_ff, ss_ff, rs_ff;

  // Decode the address phase that the slave takes on this edge.
  always_comb begin
    take = hsel && hready && htrans == gpt_pkg::HTRANS_NONSEQ;
    nxt_rd = take && !hwrite;
    nxt_ss = take && hwrite && haddr == gpt_pkg::ADDR_START_STOP;
    nxt_rs = nxt_rd && haddr == gpt_pkg::ADDR_RUN_STATE;
  end

  // One cycle is enough, because the slave never inserts wait states.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ff <= 1'b0;
      ss_ff <= 1'b0;
      rs_ff <= 1'b0;
    end else begin
      rd_ff <= nxt_rd;
      ss_ff <= nxt_ss;
      rs_ff <= nxt_rs;
    end
  end

  // ==========
  // Properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_bus_okay: assert property (hreadyout && hresp == gpt_pkg::HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |-> hrdata == 32'h0 && !running_flag && !end_event)
    else $error("outputs active in reset");
  a_read_zero: assert property (!rd_ff |-> hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");
  a_run_read: assert property (rs_ff |-> hrdata == {31'h0, $past(running_flag)})
    else $error("run state read differs from flag");
  a_start_runs: assert property (ss_ff && hwdata[gpt_pkg::START_BIT] |=> running_flag)
    else $error("start did not run the counter");
  a_stop_halts: assert property (ss_ff && hwdata[gpt_pkg::STOP_BIT] && !hwdata[0] |=> !running_flag)
    else $error("stop did not halt the counter");
  a_rise_by_start: assert property ($rose(running_flag) |-> $past(ss_ff && hwdata[0]))
    else $error("run flag rose without a start");
  a_event_in_run: assert property (end_event |-> $past(running_flag) || $past(running_flag, 2))
    else $error("end pulse while stopped");
  a_logger_gate: assert property (logger_tick |-> !$past(dsp_clock_enable))
    else $error("logger tick with core clock enabled");
endmodule : gpt_timer_chk

// >>> gpt_timer_test.sv
/*
  Self-checking bench for gpt_timer over AHB-Lite, with the reference pins.
  Assumes the design package is compiled first; a watchdog ends any hang.
*/
`timescale 1ns/1ps
module gpt_timer_test;
  logic core_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, dsp_en;
  logic running_flag, end_event, logger_tick;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, ex;
  logic [6:0] pins;
  logic [3:0] srcs [7] = '{gpt_pkg::SRC_32K, gpt_pkg::SRC_MCLK_A, gpt_pkg::SRC_MCLK_B,
    gpt_pkg::SRC_SYS, gpt_pkg::SRC_PIN_A, gpt_pkg::SRC_PIN_B, gpt_pkg::SRC_PIN_C};
  logic [15:0] reqs [3] = '{16'h0040, 16'h0080, 16'h0064};
  logic [15:0] achs [3] = '{16'h0040, 16'h0080, 16'h006A};
  logic [2:0] pres [4] = '{3'h3, 3'h3, 3'h2, 3'h1};
  logic [2:0] pcs [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  logic [3:0] dirs = 4'h3;
  int failures = 0, checks = 0, ev_cnt = 0, log_cnt = 0, cyc = 0, base, t0, k;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  gpt_timer #(.SYS_RATE_CODE(2'h3)) gpt_timer_inst (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dsp_clock_enable(dsp_en), .clk_32k_in(pins[0]),
    .master_clock_input_a(pins[1]), .master_clock_input_b(pins[2]), .main_system_clock(pins[3]),
    .general_pin_a(pins[4]), .general_pin_b(pins[5]), .general_pin_c(pins[6]),
    .running_flag(running_flag), .end_event(end_event), .logger_tick(logger_tick));

  // ==========
  // Clock and tallies
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Tests take differences of these, so nothing else ever writes them.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    ev_cnt <= ev_cnt + int'(end_event === 1'b1);
    log_cnt <= log_cnt + int'(logger_tick === 1'b1);
  end

  // ==========
  // Tasks
  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check32

  // One single transfer; entered just after a rising edge, returns on one.
  task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= gpt_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0);
    check32(rd, exp, what);
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  // Bounded, so a counter that never ends still lets the run finish.
  task automatic wait_event;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (end_event !== 1'b1 && n < 2000);
    if (n >= 2000) check32(32'h0, 32'h1, "no end pulse");
  endtask : wait_event

  function automatic logic [31:0] setup(input logic [3:0] src, input logic [2:0] sel,
      input logic [2:0] dv, input logic [2:0] pre, input logic dir, input logic cont);
    return {10'h000, cont, dir, 1'b0, pre, 1'b0, dv, 1'b0, sel, 4'h0, src};
  endfunction : setup

  task automatic final_report;
    $display("Checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Far longer than the whole sequence needs.
  initial begin
    #(20000 * 100);
    failures++;
    final_report();
  end

  // ==========
  // Test sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, pins} = '0;
    hsize = 3'h2;
    dsp_en = 1'b1;
    reset_n <= 1'b0; // Non-blocking, so the reset edge is seen by flops already waiting.
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rdchk(gpt_pkg::ADDR_RUN_STATE, 32'h0, "run state reset");
    rdchk(gpt_pkg::ADDR_READBACK, 32'h0, "count reset");
    rdchk(gpt_pkg::ADDR_SETUP, gpt_pkg::SETUP_RESET, "setup reset");
    bus(gpt_pkg::ADDR_PRESET, 1'b1, 32'hFFFF_FFFF);
    rdchk(gpt_pkg::ADDR_PRESET, 32'hFFFF_FFFF, "preset");
    bus(gpt_pkg::ADDR_SETUP, 1'b1, 32'hFFFF_FFFF);
    rdchk(gpt_pkg::ADDR_SETUP, gpt_pkg::SETUP_WMASK, "setup fields");
    bus(gpt_pkg::ADDR_READBACK, 1'b1, 32'h0000_1234);
    rdchk(gpt_pkg::ADDR_READBACK, 32'h0, "count read only");
    rdchk(gpt_pkg::ADDR_START_STOP, 32'h0, "start stop reads");
    rdchk(32'h0000_1000, 32'h0, "unmapped");
    $display("Test registers done");
    bus(gpt_pkg::ADDR_SETUP, 1'b1, 32'h0);
    for (k = 0; k < 3; k++) begin
      bus(gpt_pkg::ADDR_DSP_REQ, 1'b1, {16'h0, reqs[k]});
      idle(2);
      rdchk(gpt_pkg::ADDR_DSP_REQ, {16'h0, reqs[k]}, "rate request");
      rdchk(gpt_pkg::ADDR_DSP_ACH, {16'h0, achs[k]}, "achieved rate");
    end
    $display("Test core rate done");
    bus(gpt_pkg::ADDR_DSP_REQ, 1'b1, 32'h0000_0280);
    for (k = 0; k < 4; k++) begin
      bus(gpt_pkg::ADDR_PRESET, 1'b1, {29'h0, pres[k]});
      bus(gpt_pkg::ADDR_SETUP, 1'b1, setup(gpt_pkg::SRC_DSP, 3'h0, 3'h0, pcs[k], dirs[k], 1'b1));
      bus(gpt_pkg::ADDR_START_STOP, 1'b1, 32'h0000_0001);
      wait_event();
      t0 = cyc;
      wait_event();
      check32(32'(cyc - t0), 32'((int'(pres[k]) + 1) << pcs[k]), "end period");
      check32({31'h0, running_flag}, 32'h1, "still running");
      bus(gpt_pkg::ADDR_START_STOP, 1'b1, 32'h0000_0010);
      idle(1);
      check32({31'h0, running_flag}, 32'h0, "stopped");
    end
    bus(gpt_pkg::ADDR_PRESET, 1'b1, 32'h0000_FFFF);
    bus(gpt_pkg::ADDR_SETUP, 1'b1, setup(gpt_pkg::SRC_DSP, 3'h0, 3'h0, 3'h7, 1'b1, 1'b1));
    bus(gpt_pkg::ADDR_START_STOP, 1'b1, 32'h0000_0001);
    idle(300);
    bus(gpt_pkg::ADDR_READBACK, 1'b0, 32'h0);
    check32({31'h0, rd != 32'h0}, 32'h1, "count advanced");
    bus(gpt_pkg::ADDR_START_STOP, 1'b1, 32'h0000_0001);
    idle(1);
    bus(gpt_pkg::ADDR_READBACK, 1'b0, 32'h0);
    check32({31'h0, rd < 32'h2}, 32'h1, "restart from zero");
    bus(gpt_pkg::ADDR_START_STOP, 1'b1, 32'h0000_0010);
    $display("Test continuous done");
    bus(gpt_pkg::ADDR_PRESET, 1'b1, 32'h0000_0001);
    bus(gpt_pkg::ADDR_SETUP, 1'b1, setup(gpt_pkg::SRC_DSP, 3'h0, 3'h0, 3'h7, 1'b0, 1'b0));
    base = ev_cnt;
    bus(gpt_pkg::ADDR_START_STOP, 1'b1, 32'h0000_0001);
    k = 0;
    do begin
      bus(gpt_pkg::ADDR_READBACK, 1'b0, 32'h0);
      k++;
    end while (rd !== 32'h0 && k < 300);
    check32({31'h0, running_flag}, 32'h1, "runs past final value");
    check32(32'(ev_cnt - base), 32'h0, "no early end pulse");
    k = 0;
    do begin
      idle(1);
      k++;
    end while (running_flag !== 1'b0 && k < 400);
    idle(2);
    check32(32'(ev_cnt - base), 32'h1, "one end pulse");
    rdchk(gpt_pkg::ADDR_READBACK, 32'h0, "down ends at zero");
    rdchk(gpt_pkg::ADDR_RUN_STATE, 32'h0, "single stops");
    $display("Test single done");
    for (k = 0; k < 7; k++) begin
      dsp_en <= (k == 6);
      bus(gpt_pkg::ADDR_PRESET, 1'b1, 32'hFFFF_FFFF);
      bus(gpt_pkg::ADDR_SETUP, 1'b1, setup(srcs[k], (k == 3) ? 3'h2 : 3'h3, (k == 0) ? 3'h5 : 3'h1,
        3'h0, 1'b1, 1'b1));
      bus(gpt_pkg::ADDR_START_STOP, 1'b1, 32'h0000_0001);
      base = log_cnt;
      repeat (32) begin
        pins[k] <= 1'b1;
        idle(4);
        pins[k] <= 1'b0;
        idle(4);
      end
      idle(10);
      ex = 32'h20 >> ((k == 0) ? 5 : (k == 3) ? 2 : 1);
      rdchk(gpt_pkg::ADDR_READBACK, ex, "pin ticks");
      check32(32'(log_cnt - base), (k == 6) ? 32'h0 : ex, "logger ticks");
      bus(gpt_pkg::ADDR_START_STOP, 1'b1, 32'h0000_0010);
    end
    $display("Test pins done");
    final_report();
  end
endmodule : gpt_timer_test

bind gpt_timer gpt_timer_chk gpt_timer_chk_inst (
  .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .dsp_clock_enable(dsp_clock_enable), .running_flag(running_flag),
  .end_event(end_event), .logger_tick(logger_tick));
